// >>> design/dram_act_pkg.sv
// Purpose: Shared constants and types for the DRAM activate and mode register block
// Assumes: Core clock of 125 MHz; command pins sampled from the memory clock pin
// Notes:   Mode register addresses are six bits; data registers are one byte wide, except the three-bit single ended option copies
// ==========================================================================
// Package
// ==========================================================================
package dram_act_pkg;

	// ======================================================================
	// Mode register addresses
	// ======================================================================
	localparam logic [5:0] MA_CAPABILITY   = 6'h00;
	localparam logic [5:0] MA_IO_CONFIG    = 6'h03;
	localparam logic [5:0] MA_FSP_CONTROL  = 6'h0d;
	localparam logic [5:0] MA_LOWER_INVERT = 6'h0f;
	localparam logic [5:0] MA_UPPER_INVERT = 6'h14;
	localparam logic [5:0] MA_REFMGMT_MULT = 6'h1b;
	localparam logic [5:0] MA_CAL_FIRST    = 6'h20;
	localparam logic [5:0] MA_IGNORED_TEST = 6'h27;
	localparam logic [5:0] MA_CAL_SECOND   = 6'h28;
	localparam logic [5:0] MA_SE_OPTIONS   = 6'h33;

	// ======================================================================
	// Field positions
	// ======================================================================
	localparam int unsigned CAP_REFMGMT_BIT = 2;
	localparam int unsigned CAP_SE_BIT      = 5;
	localparam int unsigned IO_RD_INV_BIT   = 6;
	localparam int unsigned WRITE_SET_POINT_SELECTOR_BIT      = 6;
	localparam int unsigned OPERATING_SET_POINT_SELECTOR_BIT      = 7;
	localparam int unsigned SE_RD_BIT       = 0;
	localparam int unsigned SE_WR_BIT       = 1;
	localparam int unsigned SE_CK_BIT       = 2;
	localparam int unsigned SE_OP_LSB       = 1;

	// ======================================================================
	// Reset values
	// ======================================================================
	localparam logic [7:0] CAL_FIRST_RST  = 8'h5a;
	localparam logic [7:0] CAL_SECOND_RST = 8'h3c;
	localparam logic [7:0] CFG_RST        = 8'h00;

	// ======================================================================
	// Command encodings on ca[1:0] with chip select high
	// ======================================================================
	localparam logic [1:0] CA_OP_MPC  = 2'h0;
	localparam logic [1:0] CA_OP_ACT1 = 2'h1;
	localparam logic [1:0] CA_OP_MR   = 2'h2;
	localparam logic [1:0] CA_OP_ACT2 = 2'h3;
	localparam logic [6:0] MPC_RD_CAL = 7'h43;
	localparam logic [3:0] CAL_LAST   = 4'hf;
	localparam logic [1:0] MRR_HOLD   = 2'h2;

	// ======================================================================
	// Timing
	// ======================================================================
	localparam int unsigned CORE_PERIOD_PS = 8000;
	localparam int unsigned RCD_NS         = 18;
	localparam int unsigned RCD_CYC        = (RCD_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;

	// ======================================================================
	// Types
	// ======================================================================
	typedef enum logic [2:0] {CMD_IDLE, CMD_ACT2, CMD_MR2, CMD_MR3, CMD_MPC2} cmd_t;

	typedef struct packed {
		logic       cs;
		logic [5:0] ca;
	} cmd_pins_t;

	typedef struct packed {
		logic [15:0] dq;
		logic        dq_oe;
		logic [1:0]  mask_inversion_lane;
		logic        dmi_oe;
	} data_pins_t;

	typedef struct packed {
		logic dqs_t;
		logic dqs_t_oe;
		logic dqs_c;
		logic dqs_c_oe;
	} strobe_pins_t;

	typedef struct packed {
		logic              ck_s1;
		logic              ck_s2;
		logic              ck_s3;
		cmd_pins_t         cmd_s1;
		cmd_pins_t         cmd_s2;
		cmd_t              cmd;
		logic [5:0]        ma;
		logic [7:0]        op;
		logic [2:0]        act_bank;
		logic [4:0]        act_row;
		logic              act_pulse;
		logic [7:0]        cal_first;
		logic [7:0]        cal_second;
		logic [7:0]        inv_lo;
		logic [7:0]        inv_hi;
		logic [7:0]        io_cfg;
		logic [7:0]        fsp_ctl;
		logic [1:0][2:0]   se_opt;
		logic [7:0]        bank_open;
		logic [7:0]        col_ready;
		logic [7:0][3:0]   rcd_cnt;
		logic              cal_busy;
		logic [3:0]        cal_idx;
		logic [1:0]        mrr_cnt;
		data_pins_t        data;
		strobe_pins_t      strobe;
		logic [2:0]        se_active;
	} state_t;

endpackage

// >>> design/dram_activate_and_mode_regs.sv
// Purpose: Device side command decode, mode registers, activate tracking, read calibration
// Assumes: Memory clock pin is sampled by core_clk_i; commands act on its rising edges
// Notes:   Calibration data changes on both memory clock edges; mode reads hold two edges
// Summary of operation
// R1 - Refresh management count multiplier is a read-only field, valid when capability says so
// R2 - Writes to the ignored test register change nothing in the device
// R3 - Second calibration byte resets to 3c and is replaced by a write
// R4 - Read calibration sends first byte then second on all data and mask lanes
// R5 - Each pattern byte goes out least significant bit first
// R6 - Lane invert masks flip data lanes only, never the mask lanes
// R7 - Mask lanes stay undriven during calibration when read inversion is off
// R8 - No bus inversion is applied to the calibration pattern
// R9 - Read strobe mode bit picks differential or single ended; complement driven low
// R10 - Controller keeps complement write strobe valid in single ended mode
// R11 - Controller keeps complement clock valid in single ended clock mode
// R12 - Single ended options have two copies; a write hits the write-selected copy
// R13 - Device runs from the operating-selected copy; the other may be rewritten freely
// R14 - Capability register reports single ended feature support
// R15 - Activation is two back-to-back commands: ca 01 then ca 11, chip select high
// R16 - Three bank bits pick the bank, row bits pick the row to open
// R17 - Column access is allowed once the row to column delay has passed
// R18 - Controller precharges a bank and waits row cycle time before reactivating
// R19 - Controller spaces activations to different banks by the bank to bank delay
// R20 - Controller issues at most four activations in a four activate window
// R21 - Controller rounds the window up to clocks and sums time across rate changes
// R22 - Controller waits the all bank precharge time after a precharge all
// R23 - Multipurpose command operand 1000011 starts read calibration
// R24 - First calibration byte resets to 5a and is replaced by a write
// R25 - Controller keeps activation history to block a fifth activation in the window
`timescale 1ns/1ps
`default_nettype none

module dram_activate_and_mode_regs #(
	parameter logic       CAP_REFMGMT = 1'b1,
	parameter logic       CAP_SE      = 1'b1,
	parameter logic [1:0] RAA_MULT    = 2'h1,
	parameter int         NUM_BANKS   = 8
) (
	// Clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        nrst_i,
	// Memory command pins
	input  wire logic                        ck_t_i,
	input  wire dram_act_pkg::cmd_pins_t     cmd_i,
	// Data and strobe pins
	output var  dram_act_pkg::data_pins_t    data_o,
	output var  dram_act_pkg::strobe_pins_t  strobe_o,
	// Bank status
	output logic [7:0]                       bank_open_o,
	output logic [7:0]                       col_ready_o,
	output logic                             act_pulse_o,
	output logic [2:0]                       act_bank_o,
	output logic [4:0]                       act_row_o,
	// Active single ended options
	output logic                             se_wstrobe_o,
	output logic                             se_clock_o
);

	// ======================================================================
	// State
	// ======================================================================
	localparam int RCD_A = dram_act_pkg::RCD_CYC;

	dram_act_pkg::state_t st_ff;
	dram_act_pkg::state_t nxt_st;

	logic        ck_rise;
	logic        ck_edge;
	logic        wr_commit;
	logic [7:0]  wr_data;
	logic [15:0] cal_pattern;
	logic        cal_bit;

	assign ck_rise     = st_ff.ck_s2 & ~st_ff.ck_s3;
	assign ck_edge     = st_ff.ck_s2 ^ st_ff.ck_s3;
	assign wr_commit   = ck_rise && (st_ff.cmd == dram_act_pkg::CMD_MR3) && st_ff.cmd_s2.cs;
	assign wr_data     = {st_ff.cmd_s2.ca[4:0], st_ff.op[2:0]};
	assign cal_pattern = {st_ff.cal_second, st_ff.cal_first};
	assign cal_bit     = cal_pattern[st_ff.cal_idx];

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ck_s1 = ck_t_i;
		nxt_st.ck_s2 = st_ff.ck_s1;
		nxt_st.ck_s3 = st_ff.ck_s2;
		nxt_st.cmd_s1 = cmd_i;
		nxt_st.cmd_s2 = st_ff.cmd_s1;
		nxt_st.act_pulse = 1'b0;
		nxt_st.se_active = st_ff.se_opt[st_ff.fsp_ctl[dram_act_pkg::OPERATING_SET_POINT_SELECTOR_BIT]]; // [R13]

		// Row to column countdown per bank
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (st_ff.rcd_cnt[b] != 4'h0) begin
				nxt_st.rcd_cnt[b] = st_ff.rcd_cnt[b] - 4'h1;
				if (st_ff.rcd_cnt[b] == 4'h1) begin
					nxt_st.col_ready[b] = 1'b1; // [R17]
				end
			end
		end

		// Pattern and read data output on every memory clock edge
		if (ck_edge) begin
			if (st_ff.cal_busy) begin
				// Pattern is sent with the lane invert masks applied to dq, no bus inversion
				nxt_st.data.dq     = {16{cal_bit}} ^ {st_ff.inv_hi, st_ff.inv_lo}; // [R4] [R5] [R8]
				nxt_st.data.mask_inversion_lane    = {2{cal_bit}}; // [R6]
				nxt_st.data.dq_oe  = 1'b1;
				nxt_st.data.dmi_oe = st_ff.io_cfg[dram_act_pkg::IO_RD_INV_BIT]; // [R7]
				nxt_st.strobe.dqs_t    = ~st_ff.strobe.dqs_t;
				nxt_st.strobe.dqs_t_oe = 1'b1;
				nxt_st.strobe.dqs_c_oe = 1'b1;
				if (st_ff.se_active[dram_act_pkg::SE_RD_BIT]) begin
					nxt_st.strobe.dqs_c = 1'b0; // [R9]
				end else begin
					nxt_st.strobe.dqs_c = st_ff.strobe.dqs_t;
				end
				nxt_st.cal_idx = st_ff.cal_idx + 4'h1;
				if (st_ff.cal_idx == dram_act_pkg::CAL_LAST) begin
					nxt_st.cal_busy = 1'b0;
				end
			end else if (st_ff.mrr_cnt != 2'h0) begin
				nxt_st.mrr_cnt = st_ff.mrr_cnt - 2'h1;
			end else begin
				nxt_st.data.dq_oe      = 1'b0;
				nxt_st.data.dmi_oe     = 1'b0;
				nxt_st.strobe.dqs_t    = 1'b0;
				nxt_st.strobe.dqs_t_oe = 1'b0;
				nxt_st.strobe.dqs_c    = 1'b0;
				nxt_st.strobe.dqs_c_oe = 1'b0;
			end
		end

		// Command decode on memory clock rising edges
		if (ck_rise) begin
			case (st_ff.cmd)
				dram_act_pkg::CMD_IDLE: begin
					if (st_ff.cmd_s2.cs) begin
						case (st_ff.cmd_s2.ca[1:0])
							dram_act_pkg::CA_OP_MPC: begin
								nxt_st.op[3:0] = st_ff.cmd_s2.ca[5:2];
								nxt_st.cmd = dram_act_pkg::CMD_MPC2;
							end
							dram_act_pkg::CA_OP_ACT1: begin
								nxt_st.act_bank = st_ff.cmd_s2.ca[4:2]; // [R16]
								nxt_st.act_row[4] = st_ff.cmd_s2.ca[5];
								nxt_st.cmd = dram_act_pkg::CMD_ACT2; // [R15]
							end
							dram_act_pkg::CA_OP_MR: begin
								nxt_st.ma[3:0] = st_ff.cmd_s2.ca[5:2];
								nxt_st.cmd = dram_act_pkg::CMD_MR2;
							end
							default: begin
								nxt_st.cmd = dram_act_pkg::CMD_IDLE;
							end
						endcase
					end
				end
				dram_act_pkg::CMD_ACT2: begin
					// Second half must follow at once, else the activation is dropped
					if (st_ff.cmd_s2.cs && st_ff.cmd_s2.ca[1:0] == dram_act_pkg::CA_OP_ACT2) begin
						nxt_st.act_row[3:0] = st_ff.cmd_s2.ca[5:2]; // [R16]
						nxt_st.act_pulse = 1'b1; // [R15]
						nxt_st.bank_open[st_ff.act_bank] = 1'b1;
						nxt_st.col_ready[st_ff.act_bank] = 1'b0; // [R17]
						nxt_st.rcd_cnt[st_ff.act_bank] = 4'(RCD_A);
					end
					nxt_st.cmd = dram_act_pkg::CMD_IDLE;
				end
				dram_act_pkg::CMD_MR2: begin
					nxt_st.ma[5:4] = st_ff.cmd_s2.ca[1:0];
					nxt_st.op[2:0] = st_ff.cmd_s2.ca[5:3];
					nxt_st.cmd = dram_act_pkg::CMD_IDLE;
					if (st_ff.cmd_s2.ca[2]) begin
						nxt_st.data.dq     = 16'h0000;
						nxt_st.data.dq_oe  = 1'b1;
						nxt_st.data.dmi_oe = 1'b0;
						nxt_st.mrr_cnt     = dram_act_pkg::MRR_HOLD;
						nxt_st.cal_busy    = 1'b0;
						case ({st_ff.cmd_s2.ca[1:0], st_ff.ma[3:0]})
							dram_act_pkg::MA_CAPABILITY: begin
								nxt_st.data.dq[dram_act_pkg::CAP_REFMGMT_BIT] = CAP_REFMGMT;
								nxt_st.data.dq[dram_act_pkg::CAP_SE_BIT] = CAP_SE; // [R14]
							end
							dram_act_pkg::MA_REFMGMT_MULT: begin
								nxt_st.data.dq[1:0] = RAA_MULT; // [R1]
							end
							default: begin
								nxt_st.data.dq = 16'h0000;
							end
						endcase
					end else begin
						nxt_st.cmd = dram_act_pkg::CMD_MR3;
					end
				end
				dram_act_pkg::CMD_MR3: begin
					nxt_st.cmd = dram_act_pkg::CMD_IDLE;
					if (st_ff.cmd_s2.cs) begin
						case (st_ff.ma)
							dram_act_pkg::MA_IO_CONFIG:    nxt_st.io_cfg = wr_data;
							dram_act_pkg::MA_FSP_CONTROL:  nxt_st.fsp_ctl = wr_data;
							dram_act_pkg::MA_LOWER_INVERT: nxt_st.inv_lo = wr_data;
							dram_act_pkg::MA_UPPER_INVERT: nxt_st.inv_hi = wr_data;
							dram_act_pkg::MA_CAL_FIRST:    nxt_st.cal_first = wr_data; // [R24]
							dram_act_pkg::MA_CAL_SECOND:   nxt_st.cal_second = wr_data; // [R3]
							dram_act_pkg::MA_SE_OPTIONS: begin
								nxt_st.se_opt[st_ff.fsp_ctl[dram_act_pkg::WRITE_SET_POINT_SELECTOR_BIT]] =
									wr_data[dram_act_pkg::SE_OP_LSB +: 3]; // [R12]
							end
							// Test register and read-only fields swallow the write
							default: nxt_st.cmd = dram_act_pkg::CMD_IDLE; // [R2]
						endcase
					end
				end
				dram_act_pkg::CMD_MPC2: begin
					nxt_st.cmd = dram_act_pkg::CMD_IDLE;
					if (st_ff.cmd_s2.cs && {st_ff.cmd_s2.ca[2:0], st_ff.op[3:0]} ==
						dram_act_pkg::MPC_RD_CAL) begin
						nxt_st.cal_busy = 1'b1; // [R23]
						nxt_st.cal_idx  = 4'h0;
						nxt_st.mrr_cnt  = 2'h0;
					end
				end
				default: begin
					nxt_st.cmd = dram_act_pkg::CMD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff <= '0;
			st_ff.cmd <= dram_act_pkg::CMD_IDLE;
			st_ff.cal_first <= dram_act_pkg::CAL_FIRST_RST; // [R24]
			st_ff.cal_second <= dram_act_pkg::CAL_SECOND_RST; // [R3]
			st_ff.io_cfg <= dram_act_pkg::CFG_RST;
			st_ff.fsp_ctl <= dram_act_pkg::CFG_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================================
	// Outputs
	// ======================================================================
	assign data_o       = st_ff.data;
	assign strobe_o     = st_ff.strobe;
	assign bank_open_o  = st_ff.bank_open;
	assign col_ready_o  = st_ff.col_ready;
	assign act_pulse_o  = st_ff.act_pulse;
	assign act_bank_o   = st_ff.act_bank;
	assign act_row_o    = st_ff.act_row;
	assign se_wstrobe_o = st_ff.se_active[dram_act_pkg::SE_WR_BIT];
	assign se_clock_o   = st_ff.se_active[dram_act_pkg::SE_CK_BIT];

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_write_to(logic [5:0] addr);
		wr_commit && st_ff.ma == addr;
	endsequence

	sequence s_cal_edge;
		st_ff.cal_busy && ck_edge;
	endsequence

	a_test_reg_ignored: assert property ( // [R2]
		s_write_to(dram_act_pkg::MA_IGNORED_TEST) |=> $stable({st_ff.cal_first,
			st_ff.cal_second, st_ff.inv_lo, st_ff.inv_hi, st_ff.io_cfg, st_ff.fsp_ctl, st_ff.se_opt}))
		else $error("test register write changed state");

	a_second_byte_write: assert property ( // [R3]
		s_write_to(dram_act_pkg::MA_CAL_SECOND) |=> st_ff.cal_second == $past(wr_data))
		else $error("second pattern byte not replaced");

	a_first_byte_write: assert property ( // [R24]
		s_write_to(dram_act_pkg::MA_CAL_FIRST) |=> st_ff.cal_first == $past(wr_data))
		else $error("first pattern byte not replaced");

	a_cal_bit_order: assert property ( // [R4] [R5]
		s_cal_edge |=> (data_o.dq[0] ^ st_ff.inv_lo[0]) == $past(cal_pattern[st_ff.cal_idx]))
		else $error("calibration bit out of order");

	a_mask_not_inverted: assert property ( // [R6] [R8]
		data_o.dmi_oe && st_ff.mrr_cnt == 2'h0 |->
			data_o.dq == ({16{data_o.mask_inversion_lane[0]}} ^ {st_ff.inv_hi, st_ff.inv_lo}) && data_o.mask_inversion_lane[1] == data_o.mask_inversion_lane[0])
		else $error("mask lane pattern inverted or data lane mismatch");

	a_mask_gate: assert property ( // [R7]
		s_cal_edge ##0 !st_ff.io_cfg[dram_act_pkg::IO_RD_INV_BIT] |=> !data_o.dmi_oe)
		else $error("mask lanes driven with read inversion off");

	a_single_ended_read: assert property ( // [R9]
		s_cal_edge ##0 st_ff.se_active[dram_act_pkg::SE_RD_BIT] |=>
			strobe_o.dqs_c_oe && !strobe_o.dqs_c)
		else $error("complement read strobe not low");

	a_set_point_copy: assert property ( // [R12] [R13]
		s_write_to(dram_act_pkg::MA_SE_OPTIONS) ##0
			st_ff.fsp_ctl[dram_act_pkg::WRITE_SET_POINT_SELECTOR_BIT] != st_ff.fsp_ctl[dram_act_pkg::OPERATING_SET_POINT_SELECTOR_BIT]
			|=> ##1 $stable(se_clock_o) && $stable(se_wstrobe_o))
		else $error("inactive set point write changed operation");

	a_activate_opens: assert property ( // [R15] [R16]
		act_pulse_o |-> bank_open_o[act_bank_o] && !col_ready_o[act_bank_o])
		else $error("activated bank not marked open");

	a_row_to_column: assert property ( // [R17]
		act_pulse_o |-> ##(RCD_A - 1) !col_ready_o[act_bank_o] ##1 col_ready_o[act_bank_o])
		else $error("row to column delay wrong");

	a_refmgmt_read: assert property ( // [R1]
		ck_rise && st_ff.cmd == dram_act_pkg::CMD_MR2 && st_ff.cmd_s2.ca[2] &&
			{st_ff.cmd_s2.ca[1:0], st_ff.ma[3:0]} == dram_act_pkg::MA_REFMGMT_MULT
			|=> data_o.dq_oe && data_o.dq[7:0] == {6'h00, RAA_MULT})
		else $error("multiplier read returned wrong value");

endmodule

`default_nettype wire

// >>> verification/dram_activate_and_mode_regs_bench.sv
// Purpose: Self-checking bench for mode registers, calibration and activation
// Assumes: Core clock 125 MHz; controller model makes the 80 ns link clock
// Notes:   No precharge exists, so every bank is activated only once
`timescale 1ns/1ps
`default_nettype none

module dram_activate_and_mode_regs_bench;
	// ======================================================================
	// Signals
	// ======================================================================
	logic                       core_clk_i;
	logic                       nrst_i;
	logic                       ck_t;
	dram_act_pkg::cmd_pins_t    cmd;
	dram_act_pkg::data_pins_t   data;
	dram_act_pkg::strobe_pins_t strobe;
	logic [7:0]                 bank_open;
	logic [7:0]                 col_ready;
	logic                       act_pulse;
	logic [2:0]                 act_bank;
	logic [4:0]                 act_row;
	logic                       se_wstrobe;
	logic                       se_clock;
	int                         fails = 0;
	int                         tests_run = 0;
	int                         pulses = 0;

	dram_activate_and_mode_regs #(.RAA_MULT(2'h2)) uut (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ck_t_i(ck_t), .cmd_i(cmd),
		.data_o(data), .strobe_o(strobe), .bank_open_o(bank_open), .col_ready_o(col_ready),
		.act_pulse_o(act_pulse), .act_bank_o(act_bank), .act_row_o(act_row),
		.se_wstrobe_o(se_wstrobe), .se_clock_o(se_clock));

	mem_ctrl_model p (.core_clk_i(core_clk_i), .data_i(data), .strobe_i(strobe),
		.ck_t_o(ck_t), .cmd_o(cmd));

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i) begin
		if (act_pulse === 1'b1) pulses <= pulses + 1;
	end

	// ======================================================================
	// Helpers
	// ======================================================================
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("Error: %s expected %h got %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk_idle();
		chk("oe", 16'h0, 16'({data.dq_oe, data.dmi_oe, strobe.dqs_t_oe, strobe.dqs_c_oe}));
		chk("banks", 16'h0, {bank_open, col_ready});
		chk("flags", 16'h0, 16'({act_pulse, se_wstrobe, se_clock}));
	endtask

	// Mode register access with normal command timing
	task automatic mr_write(input logic [5:0] addr, input logic [7:0] d);
		p.send({addr[3:0], 2'b10});
		p.send({d[2:0], 1'b0, addr[5:4]});
		p.send({1'b0, d[7:3]});
		p.step(1'b0);
	endtask

	task automatic mr_read(input logic [5:0] addr, output logic [7:0] d);
		p.send({addr[3:0], 2'b10});
		p.send({3'b000, 1'b1, addr[5:4]});
		p.step(1'b0);
		d = p.rx_data.dq[7:0];
		p.step(1'b1);
		p.step(1'b0);
	endtask

	task automatic cal_run(input logic [7:0] first, input logic [7:0] second,
		input logic [7:0] lo, input logic [7:0] hi, input logic dmi_on, input logic se_rd);
		logic b;
		p.send(6'h0c);
		p.send(6'h04);
		for (int k = 0; k < 16; k++) begin
			p.step(k[0]);
			b = (k < 8) ? first[k] : second[k - 8];
			chk("cal dq", {{8{b}} ^ hi, {8{b}} ^ lo}, p.rx_data.dq);
			chk("cal dq_oe", 16'h1, 16'(p.rx_data.dq_oe));
			chk("cal dmi_oe", 16'(dmi_on), 16'(p.rx_data.dmi_oe));
			if (dmi_on) chk("cal dmi", 16'({2{b}}), 16'(p.rx_data.mask_inversion_lane));
			if (se_rd) chk("dqs_c", 16'h0, 16'(p.rx_strobe.dqs_c & p.rx_strobe.dqs_c_oe));
			chk("cal dqs", 16'({1'b1, !k[0], 1'b1, !se_rd && k[0]}), 16'({p.rx_strobe.dqs_t_oe,
				p.rx_strobe.dqs_t, p.rx_strobe.dqs_c_oe, p.rx_strobe.dqs_c}));
		end
		p.step(1'b0);
		chk("cal end oe", 16'h0, 16'(p.rx_data.dq_oe));
		chk("cal end dqs oe", 16'h0, 16'({p.rx_strobe.dqs_t_oe, p.rx_strobe.dqs_c_oe}));
	endtask

	// ======================================================================
	// Scenarios
	// ======================================================================
	task automatic t_reset();
		repeat (4) @(posedge core_clk_i);
		#1 chk_idle();
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		#1 chk_idle();
		$display("Test reset done");
	endtask

	task automatic t_regs();
		logic [7:0] d;
		mr_read(dram_act_pkg::MA_REFMGMT_MULT, d);
		chk("multiplier", 16'h2, 16'(d[1:0]));
		mr_write(dram_act_pkg::MA_REFMGMT_MULT, 8'h00);
		mr_read(dram_act_pkg::MA_REFMGMT_MULT, d);
		chk("multiplier read only", 16'h2, 16'(d[1:0]));
		mr_read(dram_act_pkg::MA_CAPABILITY, d);
		chk("capability", 16'h24, 16'(d & 8'h24));
		// Operand 53h must not start calibration
		p.send(6'h0c);
		p.send(6'h05);
		p.step(1'b0);
		chk("other mpc oe", 16'h0, 16'(p.rx_data.dq_oe));
		$display("Test registers done");
	endtask

	task automatic t_cal_default();
		cal_run(8'h5a, 8'h3c, 8'h00, 8'h00, 1'b0, 1'b0);
		$display("Test default calibration done");
	endtask

	task automatic t_act();
		logic [7:0] exp_open;
		int         n;
		exp_open = 8'h00;
		n = pulses;
		p.send(6'h0d);
		p.step(1'b0);
		p.step(1'b1);
		p.step(1'b0);
		chk("lone act1 pulses", 16'(n), 16'(pulses));
		chk("lone act1 open", 16'h0, 16'(bank_open));
		for (int b = 0; b < 8; b++) begin
			n = pulses;
			p.activate(3'(b), 5'(b * 5 + 3));
			chk("col early", 16'h0, 16'(col_ready[b]));
			p.step(1'b0);
			exp_open[b] = 1'b1;
			chk("act pulses", 16'(n + 1), 16'(pulses));
			chk("bank", 16'(b), 16'(act_bank));
			chk("row", 16'(b * 5 + 3) & 16'h1f, 16'(act_row));
			chk("open", 16'(exp_open), 16'(bank_open));
			chk("col ready", 16'(exp_open), 16'(col_ready));
		end
		$display("Test activate done");
	endtask

	task automatic t_se();
		mr_write(dram_act_pkg::MA_FSP_CONTROL, 8'h40);
		mr_write(dram_act_pkg::MA_SE_OPTIONS, 8'h0e);
		chk("se inactive copy", 16'h0, 16'({se_wstrobe, se_clock}));
		mr_write(dram_act_pkg::MA_FSP_CONTROL, 8'h80);
		chk("se active copy", 16'h3, 16'({se_wstrobe, se_clock}));
		mr_write(dram_act_pkg::MA_SE_OPTIONS, 8'h00);
		chk("se rewrite inactive", 16'h3, 16'({se_wstrobe, se_clock}));
		$display("Test set points done");
	endtask

	task automatic t_cal_custom();
		mr_write(dram_act_pkg::MA_IO_CONFIG, 8'h40);
		mr_write(dram_act_pkg::MA_LOWER_INVERT, 8'h0f);
		mr_write(dram_act_pkg::MA_UPPER_INVERT, 8'hf0);
		mr_write(dram_act_pkg::MA_CAL_FIRST, 8'h27);
		mr_write(dram_act_pkg::MA_CAL_SECOND, 8'hc3);
		mr_write(dram_act_pkg::MA_IGNORED_TEST, 8'hff);
		chk("se after ignored", 16'h3, 16'({se_wstrobe, se_clock}));
		cal_run(8'h27, 8'hc3, 8'h0f, 8'hf0, 1'b1, 1'b1);
		$display("Test custom calibration done");
	endtask

	// ======================================================================
	// Main sequence and hang guard
	// ======================================================================
	initial begin
		nrst_i = 1'b0;
		t_reset();
		t_cal_default();
		t_regs();
		t_act();
		t_se();
		t_cal_custom();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge core_clk_i);
		fails++;
		$display("Error: run time expected below limit got limit");
		finish_test();
	end
endmodule
`default_nettype wire

// >>> verification/mem_ctrl_model.sv
// Purpose: Memory controller model driving the clock pin and command bus of the block
// Assumes: Link clock of 80 ns made from ten core cycles; it keeps its last level between operations, high after a send
// Notes:   Released command lines show an inverting pattern; data is captured late in each half period, four core cycles after the edge
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model #(
	parameter int FAW_NS = 40,
	parameter int CK_PS  = 80000
) (
	// Core clock
	input  wire logic                       core_clk_i,
	// Device outputs
	input  wire dram_act_pkg::data_pins_t   data_i,
	input  wire dram_act_pkg::strobe_pins_t strobe_i,
	// Device inputs
	output var  logic                       ck_t_o,
	output var  dram_act_pkg::cmd_pins_t    cmd_o
);
	// ======================================================================
	// State
	// ======================================================================
	localparam int FAW_CK = (FAW_NS * 1000 + CK_PS - 1) / CK_PS;
	dram_act_pkg::data_pins_t   rx_data;
	dram_act_pkg::strobe_pins_t rx_strobe;
	int unsigned                rises;
	int unsigned                stamps[$];
	logic                       ck_c;
	logic                       wstrobe_c;

	// Complement pins held at valid levels
	assign ck_c      = ~ck_t_o;
	assign wstrobe_c = 1'b0;

	initial begin
		ck_t_o = 1'b0;
		cmd_o  = '0;
		rises  = 0;
	end

	// ======================================================================
	// Link cycles
	// ======================================================================
	task automatic step(input logic lvl);
		@(posedge core_clk_i);
		ck_t_o <= lvl;
		cmd_o  <= '{cs: 1'b0, ca: ~cmd_o.ca};
		if (lvl) rises++;
		repeat (4) @(posedge core_clk_i);
		#1;
		rx_data   = data_i;
		rx_strobe = strobe_i;
	endtask

	// One command part, stable five core cycles each side of the rise
	task automatic send(input logic [5:0] ca);
		@(posedge core_clk_i);
		ck_t_o <= 1'b0;
		cmd_o  <= '{cs: 1'b1, ca: ca};
		repeat (5) @(posedge core_clk_i);
		ck_t_o <= 1'b1;
		rises++;
		repeat (4) @(posedge core_clk_i);
		#1;
		rx_data   = data_i;
		rx_strobe = strobe_i;
	endtask

	// Two parts on consecutive rises, so activations start two rises apart, above the bank to bank delay
	task automatic activate(input logic [2:0] bank, input logic [4:0] row);
		while (stamps.size() >= 4 && rises - stamps[0] < FAW_CK) begin
			step(1'b0);
			step(1'b1);
		end
		if (stamps.size() >= 4) void'(stamps.pop_front());
		send({row[4], bank, 2'b01});
		send({row[3:0], 2'b11});
		stamps.push_back(rises);
	endtask
endmodule
`default_nettype wire
